// ### srw_pkg.sv
// constants and types for the sysref window and automatic calibration block
package srw_pkg;

  // geometry
  localparam int unsigned TAPS     = 24;
  localparam int unsigned SEL_W    = 4;
  localparam int unsigned DLY_W    = 8;
  localparam int unsigned APB_AW   = 16;
  localparam int unsigned IDX_W    = 12;

  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_FLAGS_LOW  = 12'h02C;
  localparam logic [IDX_W-1:0] IDX_FLAGS_MID  = 12'h02D;
  localparam logic [IDX_W-1:0] IDX_FLAGS_HIGH = 12'h02E;
  localparam logic [IDX_W-1:0] IDX_CLK_CTRL   = 12'h030;
  localparam logic [IDX_W-1:0] IDX_CAL_CFG    = 12'h031;
  localparam logic [IDX_W-1:0] IDX_CAL_EN     = 12'h032;
  localparam logic [IDX_W-1:0] IDX_TAD        = 12'h033;
  localparam logic [IDX_W-1:0] IDX_CAL_STAT   = 12'h034;

  // field positions
  localparam int unsigned CTRL_SEL_LSB   = 0;
  localparam int unsigned CTRL_FINE_BIT  = 4;
  localparam int unsigned CTRL_VALID_BIT = 8;
  localparam int unsigned CFG_SETTLE_LSB = 0;
  localparam int unsigned CFG_FINE_LSB   = 8;
  localparam int unsigned CAL_EN_BIT     = 0;
  localparam int unsigned DLY_INV_BIT    = 0;
  localparam int unsigned DLY_COARSE_LSB = 8;
  localparam int unsigned DLY_FINE_LSB   = 16;
  localparam int unsigned STAT_DONE_BIT  = 31;

  // reset values and counts
  localparam logic [TAPS-1:0]  FLAGS_RST       = 24'hFFFFFF;
  localparam logic [DLY_W-1:0] SETTLE_RST      = 8'h10;
  localparam logic [DLY_W-1:0] FINE_SEED_RST   = 8'h00;
  localparam logic [DLY_W-1:0] COARSE_MAX      = 8'hFF;
  localparam logic [1:0]       EDGES_FOR_VALID = 2'h3;

  typedef enum logic [1:0] {
    CAL_IDLE,
    CAL_SETTLE,
    CAL_WAIT_REF,
    CAL_DONE
  } srw_cal_state_type;

endpackage : srw_pkg

// ### srw_sysref_window.sv
// sysref position detector, sample select and automatic aperture calibration
//
// Notes on behaviour
// - 24 delayed-clock taps give 24 position flags
// - flags valid only after three sysref rises
// - flag 1 means risky, 0 means safe
// - lowest and highest flags always read one
// - select index picks the capture tap
// - select reaches only the first sixteen taps
// - step control picks coarse or fine spacing
// - enable starts delay search until edges align
// - search both polarities, keep smallest coarse
// - raise done, expose found delay setting
// - keep calibrated delay applied afterwards
// - invert bit inverts the incoming clock
`timescale 1ns/10ps
module srw_sysref_window
  import srw_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // delay line samples and phase detector
  input  wire logic              sysrefIn,
  input  wire logic [TAPS-1:0]   refTapSample,
  input  wire logic              calAligned,
  // analog controls and captured sysref
  output logic                   positionStepFine,
  output logic                   clockInvertDelay,
  output logic      [DLY_W-1:0]  coarseApertureDelay,
  output logic      [DLY_W-1:0]  fineApertureDelay,
  output logic                   refCaptured
);

  function automatic logic addrHit(input logic [APB_AW-1:0] a, input logic [IDX_W-1:0] idx);
    addrHit = (a == {idx, 2'b00});
  endfunction : addrHit

  // taps next to a level change are at risk, the two end taps always
  function automatic logic [TAPS-1:0] flagsOf(input logic [TAPS-1:0] t);
    logic [TAPS-1:0] f;
    f = FLAGS_RST;
    for (int i = 1; i < TAPS - 1; i++) begin
      f[i] = (t[i] != t[i+1]) || (t[i] != t[i-1]);
    end
    flagsOf = f;
  endfunction : flagsOf

  logic [31:0]       prdata_q;
  logic              pready_q;
  logic              pslverr_q;
  logic [SEL_W-1:0]  refSampleSelect_q;
  logic              positionStepFineReg_q;
  logic [DLY_W-1:0]  settleCount_q;
  logic [DLY_W-1:0]  fineSeed_q;
  logic              autocalEnable_q;
  logic              autocalEnablePrev_q;
  logic              dlyInv_q;
  logic [DLY_W-1:0]  dlyCoarse_q;
  logic [DLY_W-1:0]  dlyFine_q;
  logic              sysrefPrev_q;
  logic [1:0]        refEdgeCount_q;
  logic [TAPS-1:0]   refPositionFlags_q;
  logic              refCaptured_q;
  srw_cal_state_type calState_q;
  logic [DLY_W-1:0]  waitCount_q;
  logic              calInv_q;
  logic [DLY_W-1:0]  calCoarse_q;
  logic [DLY_W-1:0]  bestCoarse0_q;
  logic              found0_q;
  logic              autocalDone_q;
  logic              resultInv_q;
  logic [DLY_W-1:0]  resultCoarse_q;
  logic [DLY_W-1:0]  resultFine_q;
  logic              positionStepFine_q;
  logic              clockInvertDelay_q;
  logic [DLY_W-1:0]  coarseApertureDelay_q;
  logic [DLY_W-1:0]  fineApertureDelay_q;

  logic              apbWrite;
  logic              refRise;
  logic              calStart;
  logic              calRunning;
  logic              phaseEnd;
  logic              calFinish;
  logic              pickInv0;
  logic [31:0]       readData;
  logic              readErr;

  assign apbWrite   = psel && penable && pready_q && pwrite;
  assign refRise    = sysrefIn && !sysrefPrev_q;
  assign calStart   = autocalEnable_q && !autocalEnablePrev_q;
  assign calRunning = (calState_q == CAL_SETTLE) || (calState_q == CAL_WAIT_REF);
  assign phaseEnd   = (calState_q == CAL_WAIT_REF) && refRise
                      && (calAligned || (calCoarse_q == COARSE_MAX));
  assign calFinish  = phaseEnd && calInv_q;
  assign pickInv0   = found0_q && (!calAligned || (bestCoarse0_q <= calCoarse_q));

  // read mux
  always_comb begin
    readData = 32'h00000000;
    readErr  = 1'b0;
    if (addrHit(paddr, IDX_FLAGS_LOW)) begin
      readData[7:0] = refPositionFlags_q[7:0];
    end else if (addrHit(paddr, IDX_FLAGS_MID)) begin
      readData[7:0] = refPositionFlags_q[15:8];
    end else if (addrHit(paddr, IDX_FLAGS_HIGH)) begin
      readData[7:0] = refPositionFlags_q[23:16];
    end else if (addrHit(paddr, IDX_CLK_CTRL)) begin
      readData[CTRL_SEL_LSB +: SEL_W] = refSampleSelect_q;
      readData[CTRL_FINE_BIT]         = positionStepFineReg_q;
      readData[CTRL_VALID_BIT]        = (refEdgeCount_q == EDGES_FOR_VALID);
    end else if (addrHit(paddr, IDX_CAL_CFG)) begin
      readData[CFG_SETTLE_LSB +: DLY_W] = settleCount_q;
      readData[CFG_FINE_LSB +: DLY_W]   = fineSeed_q;
    end else if (addrHit(paddr, IDX_CAL_EN)) begin
      readData[CAL_EN_BIT] = autocalEnable_q;
    end else if (addrHit(paddr, IDX_TAD)) begin
      readData[DLY_INV_BIT]             = dlyInv_q;
      readData[DLY_COARSE_LSB +: DLY_W] = dlyCoarse_q;
      readData[DLY_FINE_LSB +: DLY_W]   = dlyFine_q;
    end else if (addrHit(paddr, IDX_CAL_STAT)) begin
      readData[DLY_INV_BIT]             = resultInv_q;
      readData[DLY_COARSE_LSB +: DLY_W] = resultCoarse_q;
      readData[DLY_FINE_LSB +: DLY_W]   = resultFine_q;
      readData[STAT_DONE_BIT]           = autocalDone_q;
    end else begin
      readErr = 1'b1;
    end
  end

  // apb handshake, one wait state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (psel && penable && !pready_q) begin
      pready_q  <= 1'b1;
      prdata_q  <= pwrite ? 32'h00000000 : readData;
      pslverr_q <= readErr;
    end else begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
  end

  // software control registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      refSampleSelect_q     <= '0;
      positionStepFineReg_q <= 1'b0;
      settleCount_q         <= SETTLE_RST;
      fineSeed_q            <= FINE_SEED_RST;
      autocalEnable_q       <= 1'b0;
    end else if (apbWrite) begin
      if (addrHit(paddr, IDX_CLK_CTRL)) begin
        refSampleSelect_q     <= pwdata[CTRL_SEL_LSB +: SEL_W];
        positionStepFineReg_q <= pwdata[CTRL_FINE_BIT];
      end
      if (addrHit(paddr, IDX_CAL_CFG)) begin
        settleCount_q <= pwdata[CFG_SETTLE_LSB +: DLY_W];
        fineSeed_q    <= pwdata[CFG_FINE_LSB +: DLY_W];
      end
      if (addrHit(paddr, IDX_CAL_EN)) begin
        autocalEnable_q <= pwdata[CAL_EN_BIT];
      end
    end
  end

  // aperture delay register, the calibration result wins over a write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dlyInv_q    <= 1'b0;
      dlyCoarse_q <= '0;
      dlyFine_q   <= '0;
    end else if (calFinish) begin
      dlyInv_q    <= !pickInv0;
      dlyCoarse_q <= pickInv0 ? bestCoarse0_q : calCoarse_q;
      dlyFine_q   <= fineSeed_q;
    end else if (apbWrite && addrHit(paddr, IDX_TAD)) begin
      dlyInv_q    <= pwdata[DLY_INV_BIT];
      dlyCoarse_q <= pwdata[DLY_COARSE_LSB +: DLY_W];
      dlyFine_q   <= pwdata[DLY_FINE_LSB +: DLY_W];
    end
  end

  // sysref edge count and position flags
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sysrefPrev_q       <= 1'b0;
      refEdgeCount_q     <= 2'h0;
      refPositionFlags_q <= FLAGS_RST;
    end else begin
      sysrefPrev_q <= sysrefIn;
      if (refRise && refEdgeCount_q != EDGES_FOR_VALID) begin
        refEdgeCount_q <= refEdgeCount_q + 2'h1;
      end
      if (refRise && refEdgeCount_q >= EDGES_FOR_VALID - 2'h1) begin
        refPositionFlags_q <= flagsOf(refTapSample);
      end
    end
  end

  // sysref capture on the selected delayed clock
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      refCaptured_q <= 1'b0;
    end else begin
      refCaptured_q <= refTapSample[refSampleSelect_q];
    end
  end

  // calibration search
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      autocalEnablePrev_q <= 1'b0;
      calState_q          <= CAL_IDLE;
      waitCount_q         <= '0;
      calInv_q            <= 1'b0;
      calCoarse_q         <= '0;
      bestCoarse0_q       <= '0;
      found0_q            <= 1'b0;
      autocalDone_q       <= 1'b0;
      resultInv_q         <= 1'b0;
      resultCoarse_q      <= '0;
      resultFine_q        <= '0;
    end else begin
      autocalEnablePrev_q <= autocalEnable_q;
      if (!autocalEnable_q) begin
        calState_q    <= CAL_IDLE;
        autocalDone_q <= 1'b0;
      end else begin
        case (calState_q)
          CAL_IDLE: begin
            if (calStart) begin
              calState_q    <= CAL_SETTLE;
              waitCount_q   <= settleCount_q;
              calInv_q      <= 1'b0;
              calCoarse_q   <= '0;
              found0_q      <= 1'b0;
              autocalDone_q <= 1'b0;
            end
          end
          CAL_SETTLE: begin
            if (waitCount_q == '0) begin
              calState_q <= CAL_WAIT_REF;
            end else begin
              waitCount_q <= waitCount_q - 8'h01;
            end
          end
          CAL_WAIT_REF: begin
            if (calFinish) begin
              calState_q     <= CAL_DONE;
              autocalDone_q  <= 1'b1;
              resultInv_q    <= !pickInv0;
              resultCoarse_q <= pickInv0 ? bestCoarse0_q : calCoarse_q;
              resultFine_q   <= fineSeed_q;
            end else if (phaseEnd) begin
              bestCoarse0_q <= calCoarse_q;
              found0_q      <= calAligned;
              calInv_q      <= 1'b1;
              calCoarse_q   <= '0;
              waitCount_q   <= settleCount_q;
              calState_q    <= CAL_SETTLE;
            end else if (refRise) begin
              calCoarse_q <= calCoarse_q + 8'h01;
              waitCount_q <= settleCount_q;
              calState_q  <= CAL_SETTLE;
            end
          end
          CAL_DONE: begin
            calState_q <= CAL_DONE;
          end
          default: begin
            calState_q <= CAL_IDLE;
          end
        endcase
      end
    end
  end

  // analog controls, delay outputs from the search while running, else the register; step always from the register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      positionStepFine_q    <= 1'b0;
      clockInvertDelay_q    <= 1'b0;
      coarseApertureDelay_q <= '0;
      fineApertureDelay_q   <= '0;
    end else begin
      positionStepFine_q    <= positionStepFineReg_q;
      clockInvertDelay_q    <= calRunning ? calInv_q : dlyInv_q;
      coarseApertureDelay_q <= calRunning ? calCoarse_q : dlyCoarse_q;
      fineApertureDelay_q   <= calRunning ? fineSeed_q : dlyFine_q;
    end
  end

  assign prdata              = prdata_q;
  assign pready              = pready_q;
  assign pslverr             = pslverr_q;
  assign positionStepFine    = positionStepFine_q;
  assign clockInvertDelay    = clockInvertDelay_q;
  assign coarseApertureDelay = coarseApertureDelay_q;
  assign fineApertureDelay   = fineApertureDelay_q;
  assign refCaptured         = refCaptured_q;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_endFlags;
    refPositionFlags_q[0] && refPositionFlags_q[TAPS-1];
  endproperty
  a_endFlags: assert property (p_endFlags) else $error("end flags not one");

  property p_notValidYet;
    (refEdgeCount_q < EDGES_FOR_VALID - 2'h1) |-> ##1 (refPositionFlags_q == FLAGS_RST);
  endproperty
  a_notValidYet: assert property (p_notValidYet) else $error("flags early");

  property p_flagsTrack;
    (refRise && refEdgeCount_q == EDGES_FOR_VALID)
      |=> (refPositionFlags_q == flagsOf($past(refTapSample)));
  endproperty
  a_flagsTrack: assert property (p_flagsTrack) else $error("flags mismatch");

  property p_safeFlag;
    (refRise && refEdgeCount_q == EDGES_FOR_VALID
     && refTapSample[6] == refTapSample[5] && refTapSample[5] == refTapSample[4])
      |=> !refPositionFlags_q[5];
  endproperty
  a_safeFlag: assert property (p_safeFlag) else $error("stable tap flagged");

  property p_capture;
    !$past(rst) |-> (refCaptured == $past(refTapSample[refSampleSelect_q]));
  endproperty
  a_capture: assert property (p_capture) else $error("capture tap wrong");

  property p_stepFine;
    (apbWrite && addrHit(paddr, IDX_CLK_CTRL)) |-> ##2 (positionStepFine == $past(pwdata[CTRL_FINE_BIT], 2));
  endproperty
  a_stepFine: assert property (p_stepFine) else $error("step control lost");

  property p_finish;
    (calState_q == CAL_WAIT_REF && refRise && calAligned && calInv_q) |=> autocalDone_q;
  endproperty
  a_finish: assert property (p_finish) else $error("search did not end");

  property p_smallest;
    $rose(autocalDone_q) && !resultInv_q |-> $past(found0_q) && resultCoarse_q == $past(bestCoarse0_q);
  endproperty
  a_smallest: assert property (p_smallest) else $error("polarity choice wrong");

  property p_result;
    $rose(autocalDone_q) |-> (dlyCoarse_q == resultCoarse_q && dlyInv_q == resultInv_q);
  endproperty
  a_result: assert property (p_result) else $error("result not applied");

  property p_doneLow;
    (calRunning |-> !autocalDone_q) and ($fell(autocalEnable_q) |=> !autocalDone_q);
  endproperty
  a_doneLow: assert property (p_doneLow) else $error("done high wrongly");

  property p_invert;
    !calRunning |=> (clockInvertDelay == $past(dlyInv_q));
  endproperty
  a_invert: assert property (p_invert) else $error("invert not applied");

  property p_hold;
    (calState_q == CAL_DONE && !(apbWrite && addrHit(paddr, IDX_TAD)))
      |=> ##1 $stable(coarseApertureDelay);
  endproperty
  a_hold: assert property (p_hold) else $error("delay drifted");

  c_valid:   cover property (refEdgeCount_q == EDGES_FOR_VALID);
  c_done0:   cover property ($rose(autocalDone_q) && !resultInv_q);
  c_done1:   cover property ($rose(autocalDone_q) && resultInv_q);
  c_slverr:  cover property (pready && pslverr);

endmodule : srw_sysref_window

// ### srw_ref_source.sv
// far-side model: periodic sysref source, delayed tap samples and phase detector
`timescale 1ns/10ps
module srw_ref_source
  import srw_pkg::*;
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // stimulus controls
  input  wire logic             run,
  input  wire logic [TAPS-1:0]  tapPattern,
  input  wire logic [DLY_W-1:0] alignCoarse0,
  input  wire logic [DLY_W-1:0] alignCoarse1,
  // delay setting seen from the device
  input  wire logic             clockInvertDelay,
  input  wire logic [DLY_W-1:0] coarseApertureDelay,
  // towards the device
  output logic                  sysrefIn,
  output logic      [TAPS-1:0]  refTapSample,
  output logic                  calAligned
);
  logic [2:0] phase_q;

  // continuous sysref, period of eight cycles, low while stopped
  always_ff @(posedge clk_sys) begin
    if (rst || !run) begin
      phase_q  <= 3'h0;
      sysrefIn <= 1'b0;
    end else begin
      phase_q  <= phase_q + 3'h1;
      sysrefIn <= phase_q[2];
    end
  end

  // taps show inverted content while sysref is stopped
  assign refTapSample = run ? tapPattern : ~tapPattern;

  // edges meet once the coarse delay reaches the threshold of the present polarity
  assign calAligned = clockInvertDelay ? (coarseApertureDelay >= alignCoarse1)
                                       : (coarseApertureDelay >= alignCoarse0);
endmodule : srw_ref_source

// ### tb.sv
// self-checking testbench for the sysref window and calibration block
`timescale 1ns/10ps
module tb;
  import srw_pkg::*;
  logic              clk_sys    = 1'b0;
  logic              rst        = 1'b1;
  logic              psel       = 1'b0;
  logic              penable    = 1'b0;
  logic              pwrite     = 1'b0;
  logic [APB_AW-1:0] paddr      = 16'h0000;
  logic [31:0]       pwdata     = 32'h00000000;
  logic              refRun     = 1'b0;
  logic [TAPS-1:0]   tapPattern = 24'hFFFC00;
  logic [DLY_W-1:0]  alignC0    = 8'h05;
  logic [DLY_W-1:0]  alignC1    = 8'h03;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              sysrefIn;
  logic [TAPS-1:0]   refTapSample;
  logic              calAligned;
  logic              positionStepFine;
  logic              clockInvertDelay;
  logic [DLY_W-1:0]  coarseApertureDelay;
  logic [DLY_W-1:0]  fineApertureDelay;
  logic              refCaptured;
  logic              prevRef    = 1'b0;
  logic [31:0]       rd;
  logic              er;
  int                errTotal   = 0;
  int                compares   = 0;
  int                riseCnt    = 0;

  always #25 clk_sys = ~clk_sys;

  srw_sysref_window srw_sysref_window_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sysrefIn(sysrefIn), .refTapSample(refTapSample),
    .calAligned(calAligned), .positionStepFine(positionStepFine),
    .clockInvertDelay(clockInvertDelay), .coarseApertureDelay(coarseApertureDelay),
    .fineApertureDelay(fineApertureDelay), .refCaptured(refCaptured));

  srw_ref_source srw_ref_source_inst (.clk_sys(clk_sys), .rst(rst), .run(refRun),
    .tapPattern(tapPattern), .alignCoarse0(alignC0), .alignCoarse1(alignC1),
    .clockInvertDelay(clockInvertDelay), .coarseApertureDelay(coarseApertureDelay),
    .sysrefIn(sysrefIn), .refTapSample(refTapSample), .calAligned(calAligned));

  // count sysref rises as the device sees them
  always @(posedge clk_sys) begin
    prevRef <= sysrefIn;
    if (sysrefIn === 1'b1 && prevRef === 1'b0) riseCnt <= riseCnt + 1;
  end

  task report_and_stop;
    $display("checks %0d mismatches %0d", compares, errTotal);
    if (errTotal == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errTotal++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // one apb transfer, request held until pready is sampled high
  task apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd,
           output logic [31:0] rdv, output logic erv);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) chk("pready", {31'h0, pready}, 32'h00000001);
    rdv = prdata;
    erv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [IDX_W-1:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd, rd, er);
  endtask : wr

  task rdchk(input string name, input logic [IDX_W-1:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h00000000, rd, er);
    chk(name, rd, exp);
  endtask : rdchk

  // poll status until the done flag rises
  task wait_done;
    int n;
    n = 0;
    do begin
      apb(1'b0, IDX_CAL_STAT, 32'h00000000, rd, er);
      n++;
    end while (rd[STAT_DONE_BIT] !== 1'b1 && n < 300);
  endtask : wait_done

  initial begin
    #(20000 * 50);
    errTotal++;
    report_and_stop();
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rdchk("flags_low", IDX_FLAGS_LOW, 32'h000000FF);
    rdchk("flags_high", IDX_FLAGS_HIGH, 32'h000000FF);
    apb(1'b1, IDX_FLAGS_LOW, 32'h00000000, rd, er);
    chk("ro_write_err", {31'h0, er}, 32'h00000000);
    refRun <= 1'b1;
    while (riseCnt < 2) @(posedge clk_sys);
    rdchk("flags_mid_two_rises", IDX_FLAGS_MID, 32'h000000FF);
    while (riseCnt < 3) @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
    rdchk("flags_low", IDX_FLAGS_LOW, 32'h00000001);
    rdchk("flags_mid", IDX_FLAGS_MID, 32'h00000006);
    rdchk("flags_high", IDX_FLAGS_HIGH, 32'h00000080);
    rdchk("flags_valid", IDX_CLK_CTRL, 32'h00000100);
    $display("test position flags done");
    for (int k = 0; k < 16; k++) begin
      wr(IDX_CLK_CTRL, {27'h0, k[0], k[3:0]});
      repeat (2) @(posedge clk_sys);
      chk("ref_captured", {31'h0, refCaptured}, {31'h0, tapPattern[k]});
      chk("step_fine", {31'h0, positionStepFine}, {31'h0, k[0]});
    end
    rdchk("ctrl", IDX_CLK_CTRL, 32'h0000011F);
    apb(1'b0, 12'h040, 32'h00000000, rd, er);
    chk("unmapped_err", {31'h0, er}, 32'h00000001);
    chk("unmapped_data", rd, 32'h00000000);
    $display("test sample select done");
    wr(IDX_CLK_CTRL, 32'h00000000);
    wr(IDX_CAL_CFG, 32'h00002201);
    wr(IDX_CAL_EN, 32'h00000001);
    apb(1'b0, IDX_CAL_STAT, 32'h00000000, rd, er);
    chk("done_busy", {31'h0, rd[STAT_DONE_BIT]}, 32'h00000000);
    wait_done();
    chk("cal_status_inv", rd, 32'h80220301);
    rdchk("tad_after_cal", IDX_TAD, 32'h00220301);
    chk("out_inv", {31'h0, clockInvertDelay}, 32'h00000001);
    chk("out_coarse", {24'h0, coarseApertureDelay}, 32'h00000003);
    chk("out_fine", {24'h0, fineApertureDelay}, 32'h00000022);
    alignC0 <= 8'h02;
    alignC1 <= 8'h04;
    wr(IDX_CAL_EN, 32'h00000000);
    apb(1'b0, IDX_CAL_STAT, 32'h00000000, rd, er);
    chk("done_cleared", {31'h0, rd[STAT_DONE_BIT]}, 32'h00000000);
    chk("kept_coarse", {24'h0, coarseApertureDelay}, 32'h00000003);
    wr(IDX_CAL_EN, 32'h00000001);
    wait_done();
    chk("cal_status_plain", rd, 32'h80220200);
    $display("test calibration done");
    wr(IDX_CAL_EN, 32'h00000000);
    wr(IDX_TAD, 32'h00112201);
    repeat (2) @(posedge clk_sys);
    chk("man_inv", {31'h0, clockInvertDelay}, 32'h00000001);
    chk("man_coarse", {24'h0, coarseApertureDelay}, 32'h00000022);
    chk("man_fine", {24'h0, fineApertureDelay}, 32'h00000011);
    $display("test manual delay done");
    report_and_stop();
  end
endmodule : tb
